// ==== softstart_startup_sequencer.v ====
// Startup and soft-start sequencer for a two-phase regulator controller
`timescale 1ns/1ps
`include "softstart_defs.vh"
module softstart_startup_sequencer #(
	parameter INITIAL_DELAY_CYC = ((`INITIAL_DELAY_NS / 1000) * (`CLK_HZ / 1000000)),
	parameter BOOT_HOLD_CYC = ((`BOOT_HOLD_NS / 1000) * (`CLK_HZ / 1000000)),
	parameter GOOD_DELAY_FP_CYC = ((`GOOD_DELAY_FP_NS / 1000) * (`CLK_HZ / 1000000)),
	parameter TABLE_DELAY_CYC = ((`TABLE_MODE_DELAY_NS / 1000) * (`CLK_HZ / 1000000)),
	parameter GOOD_DELAY_TBL_CYC = ((`GOOD_DELAY_TABLE_NS / 1000) * (`CLK_HZ / 1000000)),
	parameter STEP_CYC = (`CLK_HZ / `STEP_RATE_HZ),
	parameter SAMPLE_CYC = (`CLK_HZ / `VID_SAMPLE_HZ)
) (
	input wire ref_clk,
	input wire rst_n,
	input wire clkEn,
	input wire biasReady,
	input wire driverSupplyReady,
	input wire enableAbove,
	input wire [1:0] dacMode,
	input wire [`VID_W-1:0] voltage_id_code,
	input wire [`DAC_W-1:0] vidTarget,
	input wire vidCodeValid,
	input wire ssPinGrounded,
	input wire ssOscTick,
	input wire feedback_senseAboveRef,
	output reg [`DAC_W-1:0] dacCode_r,
	output reg pwmOe_n_r,
	output reg drivesEnable_r,
	output reg power_good_out_r,
	output reg inShutdown_r
);
	localparam [7:0] ST_SHUT = 8'h01;
	localparam [7:0] ST_DELAY1 = 8'h02;
	localparam [7:0] ST_RAMP1 = 8'h04;
	localparam [7:0] ST_HOLD = 8'h08;
	localparam [7:0] ST_RAMP2 = 8'h10;
	localparam [7:0] ST_GOODWAIT = 8'h20;
	localparam [7:0] ST_RUN = 8'h40;
	localparam [7:0] ST_TBLDELAY = 8'h80;
	localparam VALIDATE_CYC = (`VID_VALIDATE_NS * (`CLK_HZ / 1000000) + 999) / 1000;

	reg [7:0] state_r;
	reg [7:0] state_nxt;
	reg [`CNT_W-1:0] cnt_r;
	reg [`CNT_W-1:0] cnt_nxt;
	reg [`DAC_W-1:0] dac_nxt;
	reg [`DAC_W-1:0] target_r;
	reg [`DAC_W-1:0] target_nxt;
	reg [`CNT_W-1:0] valCnt_r;
	reg [`DAC_W-1:0] vidLast_r;
	reg [1:0] sameCnt_r;
	reg [`DAC_W-1:0] vidStable_r;
	reg vidOk_r;
	reg reachedRef_r;
	reg reachedRef_nxt;
	wire qualified;
	wire noLoad;
	wire startOk;
	wire fourPeriod;
	wire stepTick;
	wire rampDone;
	wire fixedTick;
	wire smpTick;

	assign qualified = biasReady & driverSupplyReady & enableAbove;
	assign noLoad = (dacMode == `MODE_TABLE5) && (voltage_id_code[4:0] == `NO_LOAD_CODE5);
	assign startOk = qualified & ~noLoad;
	assign fourPeriod = (dacMode == `MODE_FOUR_PERIOD);
	assign stepTick = (fourPeriod & ~ssPinGrounded) ? ssOscTick : fixedTick;
	assign rampDone = (dacCode_r == target_r);

	// Fixed step-rate pulse for grounded rate pin and table modes
	ss_tick_div #(
		.PERIOD(STEP_CYC),
		.W(`CNT_W)
	) stepDiv (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.tick_r(fixedTick)
	);

	// Code sampling pulse near 3 MHz
	ss_tick_div #(
		.PERIOD(SAMPLE_CYC),
		.W(`CNT_W)
	) smpDiv (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.tick_r(smpTick)
	);

	// Code filter: three identical valid samples
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vidLast_r <= `DAC_ZERO;
			sameCnt_r <= 2'h0;
			vidStable_r <= `DAC_ZERO;
			vidOk_r <= 1'b0;
		end else if (clkEn && smpTick) begin
			vidLast_r <= vidTarget;
			if (!vidCodeValid) begin
				sameCnt_r <= 2'h0;
				vidOk_r <= 1'b0;
			end else if (vidTarget != vidLast_r) begin
				sameCnt_r <= 2'h1;
				vidOk_r <= 1'b0;
			end else if (sameCnt_r != `VID_STABLE_READS) begin
				sameCnt_r <= sameCnt_r + 2'h1;
				if (sameCnt_r + 2'h1 == `VID_STABLE_READS) begin
					vidStable_r <= vidTarget;
					vidOk_r <= 1'b1;
				end
			end
		end
	end

	// Validation time runs after the fixed hold, so the two add up
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valCnt_r <= 24'h00_0000;
		end else if (clkEn) begin
			if (!vidOk_r || state_r != ST_HOLD || cnt_r != BOOT_HOLD_CYC)
				valCnt_r <= 24'h00_0000;
			else if (valCnt_r != VALIDATE_CYC)
				valCnt_r <= valCnt_r + 24'h00_0001;
		end
	end

	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		dac_nxt = dacCode_r;
		target_nxt = target_r;
		reachedRef_nxt = reachedRef_r | ~feedback_senseAboveRef;
		case (state_r)
			ST_SHUT: begin
				dac_nxt = `DAC_ZERO;
				reachedRef_nxt = 1'b0;
				cnt_nxt = 24'h00_0000;
				if (startOk) begin
					if (fourPeriod) begin
						state_nxt = ST_DELAY1;
					end else begin
						target_nxt = vidStable_r;
						if (vidOk_r == 1'b0)
							target_nxt = vidTarget;
						state_nxt = ST_TBLDELAY;
					end
				end
			end
			ST_DELAY1: begin
				cnt_nxt = cnt_r + 24'h00_0001;
				if (cnt_r == INITIAL_DELAY_CYC - 1) begin
					cnt_nxt = 24'h00_0000;
					target_nxt = `BOOT_LEVEL_CODE;
					state_nxt = ST_RAMP1;
				end
			end
			ST_RAMP1: begin
				if (rampDone) begin
					state_nxt = ST_HOLD;
					cnt_nxt = 24'h00_0000;
				end else if (stepTick) begin
					dac_nxt = dacCode_r + 8'h01;
				end
			end
			ST_HOLD: begin
				if (cnt_r != BOOT_HOLD_CYC)
					cnt_nxt = cnt_r + 24'h00_0001;
				if (cnt_r == BOOT_HOLD_CYC && valCnt_r == VALIDATE_CYC) begin
					target_nxt = vidStable_r;
					state_nxt = ST_RAMP2;
				end
			end
			ST_RAMP2, ST_TBLDELAY: begin
				if (state_r == ST_TBLDELAY && cnt_r != TABLE_DELAY_CYC - 1) begin
					cnt_nxt = cnt_r + 24'h00_0001;
				end else if (rampDone) begin
					state_nxt = ST_GOODWAIT;
					cnt_nxt = 24'h00_0000;
				end else if (stepTick) begin
					if (dacCode_r < target_r)
						dac_nxt = dacCode_r + 8'h01;
					else
						dac_nxt = dacCode_r - 8'h01;
				end
			end
			ST_GOODWAIT: begin
				reachedRef_nxt = 1'b1;
				cnt_nxt = cnt_r + 24'h00_0001;
				if ((fourPeriod && cnt_r == GOOD_DELAY_FP_CYC - 1) ||
					(!fourPeriod && cnt_r == GOOD_DELAY_TBL_CYC - 1))
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				reachedRef_nxt = 1'b1;
			end
			default: begin
				state_nxt = ST_SHUT;
			end
		endcase
		if (!qualified)
			state_nxt = ST_SHUT;
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_SHUT;
			cnt_r <= 24'h00_0000;
			dacCode_r <= `DAC_ZERO;
			target_r <= `DAC_ZERO;
			reachedRef_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			dacCode_r <= dac_nxt;
			target_r <= target_nxt;
			reachedRef_r <= reachedRef_nxt;
		end
	end

	// Status outputs follow the next state so each leaves a flop directly
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inShutdown_r <= 1'b1;
		end else if (clkEn) begin
			inShutdown_r <= (state_nxt == ST_SHUT);
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmOe_n_r <= 1'b1;
		end else if (clkEn) begin
			pwmOe_n_r <= (state_nxt == ST_SHUT);
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drivesEnable_r <= 1'b0;
		end else if (clkEn) begin
			drivesEnable_r <= (state_nxt != ST_SHUT) & reachedRef_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_good_out_r <= 1'b0;
		end else if (clkEn) begin
			power_good_out_r <= (state_nxt == ST_RUN);
		end
	end
endmodule

// Free-running divider, one-cycle pulse per period
module ss_tick_div #(
	parameter PERIOD = (`CLK_HZ / `STEP_RATE_HZ),
	parameter W = `CNT_W
) (
	input wire ref_clk,
	input wire rst_n,
	input wire clkEn,
	output reg tick_r
);
	reg [W-1:0] cnt_r;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {W{1'b0}};
			tick_r <= 1'b0;
		end else if (clkEn) begin
			if (cnt_r == PERIOD - 1) begin
				cnt_r <= {W{1'b0}};
				tick_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
				tick_r <= 1'b0;
			end
		end
	end
endmodule

// ==== softstart_defs.vh ====
// Constants for the startup and soft-start sequencer
`ifndef SOFTSTART_DEFS_VH
`define SOFTSTART_DEFS_VH
`define CLK_HZ 125000000
`define INITIAL_DELAY_NS 1400000
`define BOOT_HOLD_NS 85000
`define VID_VALIDATE_NS 500
`define GOOD_DELAY_FP_NS 440000
`define TABLE_MODE_DELAY_NS 1500000
`define GOOD_DELAY_TABLE_NS 2000000
`define STEP_RATE_HZ 330000
`define VID_SAMPLE_HZ 3000000
`define VID_STABLE_READS 2'h3
`define DAC_W 8
`define DAC_ZERO 8'h00
`define BOOT_LEVEL_CODE 8'hB0
`define NO_LOAD_CODE5 5'h1F
`define VID_W 6
`define CNT_W 24
`define MODE_FOUR_PERIOD 2'h0
`define MODE_TABLE5 2'h1
`define MODE_TABLE6 2'h2
`endif

// ==== softstart_props.sv ====
// Assertion checker for the soft-start sequencer
`timescale 1ns/1ps
`include "softstart_defs.vh"
module softstart_props (
	input wire ref_clk,
	input wire rst_n,
	input wire clkEn,
	input wire biasReady,
	input wire driverSupplyReady,
	input wire enableAbove,
	input wire [1:0] dacMode,
	input wire [`VID_W-1:0] voltage_id_code,
	input wire [`DAC_W-1:0] dacCode_r,
	input wire pwmOe_n_r,
	input wire drivesEnable_r,
	input wire power_good_out_r,
	input wire inShutdown_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire qual = biasReady && driverSupplyReady && enableAbove;
	wire startReq = clkEn && inShutdown_r && qual;
	sequence sStart;
		startReq;
	endsequence
	sequence sZeroHold;
		(dacCode_r == `DAC_ZERO)[*8];
	endsequence
	chk_shut_hiz: assert property (inShutdown_r |-> pwmOe_n_r && !drivesEnable_r && !power_good_out_r)
		else $error("outputs active in shutdown");
	chk_qual_drop: assert property (clkEn && !qual |=> inShutdown_r)
		else $error("running without qualifiers");
	chk_noload_block: assert property (startReq && dacMode == `MODE_TABLE5
		&& voltage_id_code[4:0] == `NO_LOAD_CODE5 |=> inShutdown_r) else $error("no-load start");
	chk_start_now: assert property (startReq && (dacMode == `MODE_FOUR_PERIOD
		|| dacMode == `MODE_TABLE6) |=> !inShutdown_r && !pwmOe_n_r) else $error("late start");
	chk_start_delay: assert property (sStart |=> sZeroHold)
		else $error("ramp before delay");
	chk_dac_step: assert property (clkEn && !inShutdown_r && !power_good_out_r |=> inShutdown_r
		|| dacCode_r == $past(dacCode_r) || dacCode_r == $past(dacCode_r) + 8'h01
		|| dacCode_r == $past(dacCode_r) - 8'h01) else $error("dac jumped");
	chk_good_settled: assert property ($rose(power_good_out_r)
		|-> dacCode_r == $past(dacCode_r, 8)) else $error("good before dac settled");
	chk_drive_good: assert property (power_good_out_r |-> drivesEnable_r && !pwmOe_n_r)
		else $error("good without drives");
endmodule
bind softstart_startup_sequencer softstart_props chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.clkEn(clkEn), .biasReady(biasReady), .driverSupplyReady(driverSupplyReady),
	.enableAbove(enableAbove), .dacMode(dacMode), .voltage_id_code(voltage_id_code),
	.dacCode_r(dacCode_r), .pwmOe_n_r(pwmOe_n_r), .drivesEnable_r(drivesEnable_r),
	.power_good_out_r(power_good_out_r), .inShutdown_r(inShutdown_r));

// ==== vr_stage.sv ====
// Power stage and soft-start oscillator model
`timescale 1ns/1ps
module vr_stage (
	input wire ref_clk,
	input wire [7:0] dacCode,
	input wire drivesOn,
	input wire load,
	output reg fbAbove = 1'b0,
	output reg ssOscTick = 1'b0
);
	integer vout = 0;
	integer cnt = 0;
	always @(posedge ref_clk) begin
		cnt <= (cnt + 1) % 5;
		ssOscTick <= #1 (cnt == 0);
		// Pre-charged output pinned high
		if (load)
			vout <= 255;
		else if (drivesOn)
			vout <= dacCode;
		fbAbove <= #1 (vout > dacCode);
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the soft-start sequencer
`timescale 1ns/1ps
module testbench;
	reg ref_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [2:0] qual = 3'h0;
	reg [1:0] dacMode = 2'h0;
	reg [5:0] idCode = 6'h00;
	reg [7:0] target = 8'h60;
	reg gnd = 1'b1;
	reg load = 1'b0;
	reg clkEn = 1'b1;
	reg idValid = 1'b1;
	reg [7:0] lfsr = 8'h26;
	reg [7:0] peak;
	wire [7:0] dac;
	wire oeN, drv, good, sd, fbAbove, tick;
	integer failures = 0;
	integer tests_run = 0;
	integer i;
	always #4 ref_clk = ~ref_clk;
	softstart_startup_sequencer #(.INITIAL_DELAY_CYC(20), .GOOD_DELAY_FP_CYC(10),
		.TABLE_DELAY_CYC(10), .GOOD_DELAY_TBL_CYC(10),
		.STEP_CYC(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.biasReady(qual[0]), .driverSupplyReady(qual[1]), .enableAbove(qual[2]),
		.dacMode(dacMode), .voltage_id_code(idCode), .vidTarget(target), .vidCodeValid(idValid),
		.ssPinGrounded(gnd), .ssOscTick(tick), .feedback_senseAboveRef(fbAbove),
		.dacCode_r(dac), .pwmOe_n_r(oeN), .drivesEnable_r(drv), .power_good_out_r(good),
		.inShutdown_r(sd));
	vr_stage stage (.ref_clk(ref_clk), .dacCode(dac), .drivesOn(drv), .load(load),
		.fbAbove(fbAbove), .ssOscTick(tick));
	function [7:0] lfsrNext(input [7:0] v);
		lfsrNext = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task step(input integer n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task check(input ok, input [8*16-1:0] msg);
		tests_run = tests_run + 1;
		if (ok !== 1'b1) begin
			failures = failures + 1;
			$display("unexpected at %0t: %0s", $time, msg);
		end
	endtask
	task run(input [1:0] m, input g, input pre);
		lfsr = lfsrNext(lfsr);
		target = {2'h1, lfsr[5:0]};
		idValid = 1'b0;
		qual = 3'h0;
		step(60);
		idValid = 1'b1;
		step(130);
		dacMode = m;
		gnd = g;
		load = pre;
		idCode = 6'h0A;
		qual = 3'h7;
		step(1);
		check(sd === 1'b0 && oeN === 1'b0, "no start");
		step(6);
		check(dac === 8'h00 && drv === !fbAbove, "early ramp");
		peak = 8'h00;
		for (i = 0; i < 16000 && good !== 1'b1; i = i + 1) begin
			step(1);
			if (dac > peak)
				peak = dac;
			check(!pre || drv === 1'b0 || dac === target, "early drive");
		end
		check(good === 1'b1 && dac === target && drv === 1'b1, "bad finish");
		check(m !== 2'h0 || peak === 8'hB0, "no boot level");
		load = 1'b0;
	endtask
	task close_out;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		step(10);
		rst_n = 1'b1;
		check(sd === 1'b1 && oeN === 1'b1 && dac === 8'h00, "reset state");
		for (i = 0; i < 3; i = i + 1) begin
			qual = 3'h7 ^ (3'h1 << i);
			step(3);
			check(sd === 1'b1 && oeN === 1'b1, "left shutdown");
		end
		clkEn = 1'b0;
		qual = 3'h7;
		step(3);
		check(sd === 1'b1 && oeN === 1'b1 && dac === 8'h00, "ran frozen");
		clkEn = 1'b1;
		dacMode = 2'h1;
		idCode = 6'h3F;
		qual = 3'h7;
		step(3);
		check(sd === 1'b1, "no-load start");
		run(2'h0, 1'b1, 1'b0);
		run(2'h0, 1'b0, 1'b0);
		run(2'h2, 1'b1, 1'b1);
		run(2'h1, 1'b1, 1'b0);
		qual = 3'h5;
		step(1);
		check(sd === 1'b1 && oeN === 1'b1 && good === 1'b0, "still running");
		close_out;
	end
	initial begin
		#400000;
		failures = failures + 1;
		close_out;
	end
endmodule
